// ===== angle_pkg.sv
// Constants and types for the gimbal angle phase counter.
// Assumes a single 100 MHz system clock and zero-crossing comparator inputs.
package angle_pkg;
   localparam int AXES = 3;
   localparam int CNT_W = 12;
   localparam int unsigned SYS_CLK_HZ = 100_000_000;
   localparam int unsigned COUNT_CLK_HZ = 2_048_000;
   localparam int unsigned EXCITE_HZ = 1016;
   localparam int ACC_W = 32;
   // Phase accumulator step giving the counting rate from the system clock.
   localparam logic [ACC_W-1:0] COUNT_STEP =
      ACC_W'((64'(COUNT_CLK_HZ) << ACC_W) / 64'(SYS_CLK_HZ));
   // Two excitation periods in counting ticks plus 64 ticks of margin; no crossing means a lost channel.
   localparam int unsigned LOSS_TICKS = 2 * (COUNT_CLK_HZ / EXCITE_HZ) + 64;
   localparam logic [CNT_W-1:0] LOSS_LIMIT = CNT_W'(LOSS_TICKS);
   localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
   typedef enum logic [1:0] {
      GATE_IDLE = 2'b01,
      GATE_OPEN = 2'b10
   } gate_state_t;
endpackage

// ===== gate_counter.sv
// One gated phase counter: a start crossing opens it, a stop crossing closes it.
// Assumes inputs are already synchronised and ticks are one-cycle pulses.
`timescale 1ns/1ps
module gate_counter (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic start_edge,
   input wire logic stop_edge,
   output logic [angle_pkg::CNT_W-1:0] result,
   output logic done,
   output logic lost
);
   import angle_pkg::*;
   gate_state_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt, result_r, result_nxt;
   logic [CNT_W-1:0] idle_r, idle_nxt;
   logic done_r, lost_r;
   wire opening = (state_r == GATE_IDLE) && start_edge;
   wire closing = (state_r == GATE_OPEN) && stop_edge;
   wire idle_full = (idle_r >= LOSS_LIMIT);
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      result_nxt = result_r;
      unique case (state_r)
         GATE_IDLE: begin
            if (start_edge) begin
               state_nxt = GATE_OPEN;
               cnt_nxt = CNT_RESET;
            end
         end
         GATE_OPEN: begin
            if (stop_edge) begin
               state_nxt = GATE_IDLE;
               result_nxt = cnt_r;
            end else if (tick) begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: state_nxt = GATE_IDLE;
      endcase
   end
   // The watchdog counts ticks since the last completed measurement.
   assign idle_nxt = closing ? CNT_RESET : (tick && !idle_full) ? idle_r + 1'b1 : idle_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= GATE_IDLE;
         cnt_r <= CNT_RESET;
         result_r <= CNT_RESET;
         idle_r <= CNT_RESET;
         done_r <= 1'b0;
         lost_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         result_r <= result_nxt;
         idle_r <= idle_nxt;
         done_r <= closing;
         lost_r <= closing ? 1'b0 : (idle_full ? 1'b1 : lost_r);
      end
   end
   assign result = result_r;
   assign done = done_r;
   assign lost = lost_r;
   wire unused_ok = opening;
endmodule

// ===== gimbal_angle_phase_counter.sv
// Top level: three pivots, each with a fine and a coarse gated phase counter.
// Assumes the crossing inputs are comparator levels from the analogue bridge.
`timescale 1ns/1ps
module gimbal_angle_phase_counter (
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Zero-crossing comparator levels, one bit per pivot X, Y, Z, and one shared excitation reference bit.
   input wire logic [angle_pkg::AXES-1:0] FINE_START_PHASE_SIGNAL,
   input wire logic [angle_pkg::AXES-1:0] FINE_STOP_PHASE_SIGNAL,
   input wire logic [angle_pkg::AXES-1:0] COARSE_START_SIGNAL,
   input wire logic RESOLVER_EXCITATION_REF,
   // Angle results.
   output logic [angle_pkg::CNT_W-1:0] ANGLE_X,
   output logic [angle_pkg::CNT_W-1:0] ANGLE_Y,
   output logic [angle_pkg::CNT_W-1:0] ANGLE_Z,
   output logic [angle_pkg::AXES-1:0] ANGLE_VALID,
   output logic [angle_pkg::AXES-1:0] FINE_LOST,
   output logic [angle_pkg::AXES-1:0] COARSE_USED
);
   import angle_pkg::*;
   localparam int NIN = 3 * AXES + 1;
   logic [NIN-1:0] sync1_r, sync2_r, prev_r;
   logic [ACC_W-1:0] fine_acc_r, coarse_acc_r;
   logic fine_tick_r, coarse_tick_r;
   logic [CNT_W-1:0] fine_res [AXES];
   logic [CNT_W-1:0] coarse_res [AXES];
   logic [AXES-1:0] fine_done, coarse_done, fine_lost, coarse_lost;
   logic [CNT_W-1:0] angle_r [AXES];
   logic [AXES-1:0] valid_r, used_r, lost_r;
   wire [NIN-1:0] pins = {RESOLVER_EXCITATION_REF, COARSE_START_SIGNAL,
                          FINE_STOP_PHASE_SIGNAL, FINE_START_PHASE_SIGNAL};
   wire [NIN-1:0] rise = sync2_r & ~prev_r;
   wire [ACC_W:0] fine_sum = {1'b0, fine_acc_r} + {1'b0, COUNT_STEP};
   wire [ACC_W:0] coarse_sum = {1'b0, coarse_acc_r} + {1'b0, COUNT_STEP};
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end
   // Two tick sources share one step constant, so both follow the common standard.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         fine_acc_r <= '0;
         coarse_acc_r <= '0;
         fine_tick_r <= 1'b0;
         coarse_tick_r <= 1'b0;
      end else begin
         fine_acc_r <= fine_sum[ACC_W-1:0];
         coarse_acc_r <= coarse_sum[ACC_W-1:0];
         fine_tick_r <= fine_sum[ACC_W];
         coarse_tick_r <= coarse_sum[ACC_W];
      end
   end
   for (genvar a = 0; a < AXES; a++) begin : g_axis
      gate_counter u_fine (
         .clk(SYS_CLK),
         .rst(SYS_RST),
         .tick(fine_tick_r),
         .start_edge(rise[a]),
         .stop_edge(rise[AXES + a]),
         .result(fine_res[a]),
         .done(fine_done[a]),
         .lost(fine_lost[a])
      );
      gate_counter u_coarse (
         .clk(SYS_CLK),
         .rst(SYS_RST),
         .tick(coarse_tick_r),
         .start_edge(rise[2 * AXES + a]),
         .stop_edge(rise[3 * AXES]),
         .result(coarse_res[a]),
         .done(coarse_done[a]),
         .lost(coarse_lost[a])
      );
      wire take_coarse = fine_lost[a] && !coarse_lost[a];
      wire load = take_coarse ? coarse_done[a] : fine_done[a];
      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) begin
            angle_r[a] <= CNT_RESET;
            valid_r[a] <= 1'b0;
            used_r[a] <= 1'b0;
            lost_r[a] <= 1'b1;
         end else begin
            if (load) begin
               angle_r[a] <= take_coarse ? coarse_res[a] : fine_res[a];
            end
            valid_r[a] <= load;
            used_r[a] <= take_coarse;
            lost_r[a] <= fine_lost[a];
         end
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ANGLE_X <= CNT_RESET;
         ANGLE_Y <= CNT_RESET;
         ANGLE_Z <= CNT_RESET;
         ANGLE_VALID <= '0;
         FINE_LOST <= '1;
         COARSE_USED <= '0;
      end else begin
         ANGLE_X <= angle_r[0];
         ANGLE_Y <= angle_r[1];
         ANGLE_Z <= angle_r[2];
         ANGLE_VALID <= valid_r;
         FINE_LOST <= lost_r;
         COARSE_USED <= used_r;
      end
   end
endmodule

// ===== angle_chk.sv
// Port checker for the gimbal angle phase counter.
// Assumes the bind below and one clock domain.
`timescale 1ns/1ps
module angle_chk (
   // Clock, reset and crossings.
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [angle_pkg::AXES-1:0] FINE_STOP_PHASE_SIGNAL,
   input wire logic RESOLVER_EXCITATION_REF,
   // Results.
   input wire logic [angle_pkg::CNT_W-1:0] ANGLE_X,
   input wire logic [angle_pkg::CNT_W-1:0] ANGLE_Z,
   input wire logic [angle_pkg::AXES-1:0] ANGLE_VALID,
   input wire logic [angle_pkg::AXES-1:0] FINE_LOST,
   input wire logic [angle_pkg::AXES-1:0] COARSE_USED
);
   import angle_pkg::*;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   AST_X_HOLD: assert property (!ANGLE_VALID[0] |-> $stable(ANGLE_X)) else $error("x moved");
   AST_Z_HOLD: assert property (!ANGLE_VALID[2] |-> $stable(ANGLE_Z)) else $error("z moved");
   AST_PULSE: assert property (ANGLE_VALID != 3'h0 |=> (ANGLE_VALID & $past(ANGLE_VALID)) == 3'h0)
      else $error("valid too long");
   AST_SEL: assert property ((COARSE_USED & ~FINE_LOST) == 3'h0) else $error("coarse used");
   AST_X_FINE: assert property (ANGLE_VALID[0] && !FINE_LOST[0] |-> FINE_STOP_PHASE_SIGNAL[0]
      && !$past(FINE_STOP_PHASE_SIGNAL[0], 8)) else $error("x not on stop");
   AST_Y_FINE: assert property (ANGLE_VALID[1] && !FINE_LOST[1] |-> FINE_STOP_PHASE_SIGNAL[1]
      && !$past(FINE_STOP_PHASE_SIGNAL[1], 8)) else $error("y not on stop");
   AST_X_COARSE: assert property (ANGLE_VALID[0] && COARSE_USED[0] && !FINE_STOP_PHASE_SIGNAL[0]
      |-> RESOLVER_EXCITATION_REF && !$past(RESOLVER_EXCITATION_REF, 8))
      else $error("coarse not on ref");
   AST_LOST_CLR: assert property (ANGLE_VALID[0] && FINE_STOP_PHASE_SIGNAL[0] |-> ##[0:3]
      !FINE_LOST[0]) else $error("lost kept");
   COV_X: cover property (ANGLE_VALID[0]);
   COV_Z: cover property (ANGLE_VALID[2]);
   COV_COARSE: cover property (ANGLE_VALID[0] && COARSE_USED[0]);
endmodule
bind gimbal_angle_phase_counter angle_chk u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
   .FINE_STOP_PHASE_SIGNAL(FINE_STOP_PHASE_SIGNAL), .RESOLVER_EXCITATION_REF(RESOLVER_EXCITATION_REF),
   .ANGLE_X(ANGLE_X), .ANGLE_Z(ANGLE_Z), .ANGLE_VALID(ANGLE_VALID), .FINE_LOST(FINE_LOST),
   .COARSE_USED(COARSE_USED));

// ===== resolver_model.sv
// Resolver bridge model giving comparator levels per pivot.
// Assumes delays in system cycles; the period is shortened to keep runs short.
`timescale 1ns/1ps
module resolver_model (
   // Clock and settings.
   input wire logic clk,
   input wire logic fine_on,
   input wire logic [29:0] dly,
   input wire logic [9:0] dly_c,
   // Comparator levels.
   output logic [2:0] fine_start,
   output logic [2:0] fine_stop,
   output logic [2:0] coarse_start,
   output logic ref_out
);
   logic [9:0] cnt = 10'h000;
   always_ff @(posedge clk) begin
      cnt <= (cnt == 10'h3e7) ? 10'h000 : cnt + 10'h001;
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         fine_start[i] = fine_on && cnt < 10'h014;
         fine_stop[i] = fine_on && 10'(cnt - dly[i*10 +: 10]) < 10'h014;
         coarse_start[i] = cnt < 10'h014;
      end
      ref_out = 10'(cnt - dly_c) < 10'h014;
   end
endmodule

// ===== test_gimbal_angle_phase_counter.sv
// Bench for the gimbal angle phase counter: delay table, coarse and reset cases.
// Assumes the resolver model and the bound checker are compiled with it.
`timescale 1ns/1ps
module test_gimbal_angle_phase_counter;
   import angle_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fine_on = 1'b0;
   logic [29:0] dly = 30'h0;
   logic [9:0] dly_c = 10'h2bc;
   logic [2:0] f_st, f_sp, c_st;
   logic ex_ref;
   logic [CNT_W-1:0] ang [3];
   logic [AXES-1:0] vld, lost, used;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   logic [29:0] rows [3] = '{{10'h3b6, 10'h1f4, 10'h031}, {10'h031, 10'h3b6, 10'h1f4},
      {10'h1f4, 10'h031, 10'h3b6}};
   resolver_model u_res (.clk(sys_clk), .fine_on(fine_on), .dly(dly), .dly_c(dly_c),
      .fine_start(f_st), .fine_stop(f_sp), .coarse_start(c_st), .ref_out(ex_ref));
   gimbal_angle_phase_counter u_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
      .FINE_START_PHASE_SIGNAL(f_st), .FINE_STOP_PHASE_SIGNAL(f_sp), .COARSE_START_SIGNAL(c_st),
      .RESOLVER_EXCITATION_REF(ex_ref), .ANGLE_X(ang[0]), .ANGLE_Y(ang[1]), .ANGLE_Z(ang[2]),
      .ANGLE_VALID(vld), .FINE_LOST(lost), .COARSE_USED(used));
   initial forever #5 sys_clk = ~sys_clk;
   function automatic int exp_cnt(input logic [9:0] d);
      return int'(64'(d) * COUNT_CLK_HZ / SYS_CLK_HZ);
   endfunction
   task automatic chk(input logic [CNT_W-1:0] g, input int e, input int t, input string m);
      check_count++;
      if ((^g === 1'bx) || (g > e + t) || (g + t < e)) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %0d want %0d", $time, m, g, e);
      end
   endtask
   task automatic wv(input int i);
      do begin
         @(posedge sys_clk);
         #1;
      end while (vld[i] !== 1'b1);
   endtask
   task automatic do_rst();
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(ang[0] | ang[1] | ang[2], 0, 0, "angle after reset");
      chk(CNT_W'({vld, used}), 0, 0, "flags after reset");
      chk(CNT_W'(lost), 7, 0, "lost after reset");
   endtask
   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      do_rst();
      wv(0);
      wv(0);
      chk(ang[0], exp_cnt(dly_c), 1, "coarse angle");
      chk(ang[1], exp_cnt(dly_c), 1, "coarse angle y");
      chk(ang[2], exp_cnt(dly_c), 1, "coarse angle z");
      chk(CNT_W'(used), 7, 0, "coarse selected");
      foreach (rows[r]) begin
         @(posedge sys_clk);
         fine_on <= 1'b1;
         dly <= rows[r];
         for (int i = 0; i < 3; i++) begin
            wv(i);
            wv(i);
            chk(ang[i], exp_cnt(rows[r][i*10 +: 10]), 1, "fine angle");
         end
         chk(CNT_W'({lost, used}), 0, 0, "fine back");
      end
      do_rst();
      stop_test();
   end
endmodule
